/* File: rtl/dfc_consts.vh */
`ifndef DFC_CONSTS_VH
`define DFC_CONSTS_VH
// Multi-function input setting codes.
`define DFC_FN_RAMP_HOLD   8'h0A
`define DFC_FN_UP          8'h10
`define DFC_FN_DOWN        8'h11
`define DFC_FN_FAULT_RST   8'h14
`define DFC_FN_PID_OFF     8'h19
`define DFC_FN_LOCKOUT     8'h1B
`define DFC_FN_TRIM_INC    8'h1C
`define DFC_FN_TRIM_DEC    8'h1D
`define DFC_FN_SAMPLE_HOLD 8'h1E
`define DFC_FN_JOG         8'h06
`define DFC_FN_NONE        8'h0F
// Selector values.
`define DFC_RUN_SRC_TERM   2'h1
`define DFC_HOLD_ON        1'h1
`define DFC_PERCENT_DIV    16'h0064
// Sample/hold time in milliseconds and clock rate in kHz.
`define DFC_SH_TIME_MS     100
`define DFC_CLK_KHZ        50000
`define DFC_SH_CYCLES      (`DFC_SH_TIME_MS * `DFC_CLK_KHZ)
// Ramp step prescale: one frequency step per this many cycles per unit of ramp time.
`define DFC_RAMP_PRESCALE  24'h00_0032
`define DFC_ZERO_FREQ      16'h0000
`define DFC_FREQ_STEP      16'h0001
`define DFC_FREQ_FULL      16'hFFFF
// Number of multi-function input pins.
`define DFC_N_PINS         6
`endif

/* File: rtl/dfc_freq_cmd.v */
// Operation
// - Up accelerates, down decelerates, else hold
// - Flag error when up/down unpaired
// - Up/down acts only with terminal run source
// - Up/down uses normal ramp times
// - Clamp up/down between percentage limits
// - Analog reference raises effective lower limit
// - Run command ramps up to lower limit
// - Active jog overrides up/down
// - Up/down disables multi-step references
// - Hold selector stores frequency across power loss
// - Up/down while stopped erases stored frequency
// - Error on more than one exclusive function
// - Speed agree when running and steady
// - Fault reset clears only on rising edge
// - Fault reset refused while running
// - PID disable selects open loop
// - Lockout off blocks non-frequency writes
// - Trim adds or subtracts trim level
// - Trim only for analog reference
// - Trim subtraction clamps at zero
// - Sample analog after 100 ms on
// - Sample/hold covers every analog input
`timescale 1ns/1ps
`default_nettype none
`include "dfc_consts.vh"
module dfc_freq_cmd #(
  parameter [31:0] SH_CYCLES = `DFC_SH_CYCLES
) (
  // Clock and reset.
  input  wire        clk_i,
  input  wire        nrst_i,
  // Multi-function input pins and their function assignments.
  input  wire [5:0]  mfi_pin_i,
  input  wire [47:0] mfi_func_i,
  // Run control and settings.
  input  wire        run_cmd_i,
  input  wire [1:0]  run_source_selector_i,
  input  wire [15:0] maximum_frequency_setting_i,
  input  wire [7:0]  upper_limit_percent_i,
  input  wire [7:0]  lower_limit_percent_i,
  input  wire        hold_memory_selector_i,
  input  wire [15:0] trim_level_setting_i,
  input  wire [15:0] ramp_time_i,
  // Frequency references.
  input  wire        analog_ref_sel_i,
  input  wire [15:0] analog_ref_i,
  input  wire [15:0] aux_analog_i,
  input  wire [15:0] card_analog_i,
  input  wire [15:0] jog_freq_i,
  input  wire [15:0] ref_freq_i,
  // Non-volatile store.
  input  wire [15:0] nv_freq_i,
  input  wire        nv_valid_i,
  output reg         nv_write_o,
  output reg         nv_erase_o,
  output reg  [15:0] nv_freq_o,
  // Fault and parameter logic.
  input  wire        fault_i,
  output reg         fault_clear_o,
  input  wire        param_wr_req_i,
  input  wire        param_is_freq_i,
  output wire        param_wr_ok_o,
  // Status and results.
  output reg  [15:0] out_freq_o,
  output reg  [15:0] held_analog_o,
  output reg  [15:0] held_aux_o,
  output reg  [15:0] held_card_o,
  output reg         speed_agree_o,
  output wire        pid_enable_o,
  output wire        multistep_en_o,
  output wire        missing_pair_setting_error_o,
  output wire        conflicting_function_error_o
);

////////////////////////////////////////////////////////////////////////////////
// Input synchroniser: three stages per pin, a change counts when the last two agree.
// The filter costs one cycle of latency, but a single noisy sample never reaches the decode.
wire [5:0] pin_q;
genvar b;
generate
  for (b = 0; b < `DFC_N_PINS; b = b + 1) begin : g_sync
    reg s1_q;
    reg s2_q;
    reg s3_q;
    reg flt_q;
    always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        s1_q  <= 1'b0;
        s2_q  <= 1'b0;
        s3_q  <= 1'b0;
        flt_q <= 1'b0;
      end else begin
        s1_q <= mfi_pin_i[b];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q)
          flt_q <= s2_q;
      end
    end
    assign pin_q[b] = flt_q;
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Function decode, one slice per input.
wire [5:0] is_up;
wire [5:0] is_dn;
wire [5:0] is_fr;
wire [5:0] is_pid;
wire [5:0] is_lock;
wire [5:0] is_ti;
wire [5:0] is_td;
wire [5:0] is_sh;
wire [5:0] is_rh;
wire [5:0] is_jog;
genvar g;
generate
  for (g = 0; g < `DFC_N_PINS; g = g + 1) begin : g_dec
    wire [7:0] f = mfi_func_i[g*8 +: 8];
    assign is_up[g]   = (f == `DFC_FN_UP);
    assign is_dn[g]   = (f == `DFC_FN_DOWN);
    assign is_fr[g]   = (f == `DFC_FN_FAULT_RST);
    assign is_pid[g]  = (f == `DFC_FN_PID_OFF);
    assign is_lock[g] = (f == `DFC_FN_LOCKOUT);
    assign is_ti[g]   = (f == `DFC_FN_TRIM_INC);
    assign is_td[g]   = (f == `DFC_FN_TRIM_DEC);
    assign is_sh[g]   = (f == `DFC_FN_SAMPLE_HOLD);
    assign is_rh[g]   = (f == `DFC_FN_RAMP_HOLD);
    assign is_jog[g]  = (f == `DFC_FN_JOG);
  end
endgenerate

wire has_up  = |is_up;
wire has_dn  = |is_dn;
wire has_ud  = has_up & has_dn;
wire has_tr  = |(is_ti | is_td);
wire has_sh  = |is_sh;
wire has_rh  = |is_rh;
wire up_on   = |(is_up & pin_q);
wire dn_on   = |(is_dn & pin_q);
wire jog_on  = |(is_jog & pin_q);
wire fr_on   = |(is_fr & pin_q);
wire ti_on   = |(is_ti & pin_q);
wire td_on   = |(is_td & pin_q);
wire sh_on   = |(is_sh & pin_q);
wire lock_on = |(is_lock & pin_q);
wire pid_off = |(is_pid & pin_q);

assign missing_pair_setting_error_o = has_up ^ has_dn;
wire [2:0] excl_cnt = {2'b00, has_rh} + {2'b00, (has_up | has_dn)} + {2'b00, has_tr} + {2'b00, has_sh};
assign conflicting_function_error_o = (excl_cnt > 3'h1);
wire cfg_ok = ~missing_pair_setting_error_o & ~conflicting_function_error_o;

assign multistep_en_o = ~has_ud;
assign pid_enable_o   = ~pid_off;
// Frequency changes stay writable even in lockout so the operator can still steer speed.
assign param_wr_ok_o  = param_wr_req_i & (lock_on | param_is_freq_i);

////////////////////////////////////////////////////////////////////////////////
// Limits.
wire [23:0] up_prod = maximum_frequency_setting_i * upper_limit_percent_i;
wire [23:0] lo_prod = maximum_frequency_setting_i * lower_limit_percent_i;
wire [23:0] up_quo  = up_prod / {8'h00, `DFC_PERCENT_DIV};
wire [23:0] lo_quo  = lo_prod / {8'h00, `DFC_PERCENT_DIV};
// Percentages above one hundred can overflow the frequency width; settings must stay within it.
wire [15:0] up_lim  = up_quo[15:0];
wire [15:0] lo_cfg  = lo_quo[15:0];
wire [15:0] lo_lim  = (analog_ref_sel_i && analog_ref_i > lo_cfg) ? analog_ref_i : lo_cfg;

////////////////////////////////////////////////////////////////////////////////
// Ramp tick: the step interval follows the normal ramp time setting.
reg  [23:0] tick_cnt_q;
wire [23:0] tick_top = ramp_time_i * `DFC_RAMP_PRESCALE;
wire        tick     = (tick_cnt_q >= tick_top);
always @(posedge clk_i or negedge nrst_i) begin
  if (!nrst_i)
    tick_cnt_q <= 24'h00_0000;
  else if (tick)
    tick_cnt_q <= 24'h00_0000;
  else
    tick_cnt_q <= tick_cnt_q + 24'h00_0001;
end

////////////////////////////////////////////////////////////////////////////////
// Up/down target and output ramp.
wire ud_act = has_ud & cfg_ok & (run_source_selector_i == `DFC_RUN_SRC_TERM);
reg  [15:0] ud_q;
reg  [15:0] freq_q;
reg         run_q;
reg         ud_in_q;
wire        run_rise = run_cmd_i & ~run_q;

wire [15:0] trim_add = (ref_freq_i > `DFC_FREQ_FULL - trim_level_setting_i) ? `DFC_FREQ_FULL
                       : ref_freq_i + trim_level_setting_i;
wire [15:0] trim_sub = (ref_freq_i < trim_level_setting_i) ? `DFC_ZERO_FREQ
                       : ref_freq_i - trim_level_setting_i;
reg  [15:0] base_ref;
always @* begin
  base_ref = ref_freq_i;
  if (has_tr && analog_ref_sel_i && ti_on && !td_on)
    base_ref = trim_add;
  else if (has_tr && analog_ref_sel_i && td_on && !ti_on)
    base_ref = trim_sub;
end

wire [15:0] target = !run_cmd_i ? `DFC_ZERO_FREQ :
                     jog_on     ? jog_freq_i :
                     ud_act     ? ud_q : base_ref;
wire accel = run_cmd_i && (freq_q < target);
wire decel = freq_q > target;
// The erase acts once per press, so a held button does not keep rewriting the store.
wire ud_edge = ud_act && !run_cmd_i && (up_on || dn_on) && !ud_in_q;
// A run start takes priority over a step in the same cycle.
wire ud_step = ud_act && run_cmd_i && !run_rise && !jog_on && tick;

////////////////////////////////////////////////////////////////////////////////
// Up/down target register.
always @(posedge clk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    run_q <= 1'b0;
    ud_q  <= `DFC_ZERO_FREQ;
  end else begin
    run_q <= run_cmd_i;
    if (ud_edge) begin
      ud_q <= lo_lim;
    end else if (ud_act && run_rise) begin
      if (hold_memory_selector_i == `DFC_HOLD_ON && nv_valid_i && nv_freq_i > lo_lim)
        ud_q <= (nv_freq_i > up_lim) ? up_lim : nv_freq_i;
      else
        ud_q <= lo_lim;
    end else if (ud_step) begin
      if (up_on && !dn_on && ud_q < up_lim)
        ud_q <= ud_q + `DFC_FREQ_STEP;
      else if (dn_on && !up_on && ud_q > lo_lim)
        ud_q <= ud_q - `DFC_FREQ_STEP;
      else if (ud_q > up_lim)
        ud_q <= up_lim;
      else if (ud_q < lo_lim)
        ud_q <= lo_lim;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Non-volatile store requests.
always @(posedge clk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    ud_in_q    <= 1'b0;
    nv_write_o <= 1'b0;
    nv_erase_o <= 1'b0;
    nv_freq_o  <= `DFC_ZERO_FREQ;
  end else begin
    ud_in_q    <= up_on | dn_on;
    nv_erase_o <= ud_edge;
    nv_write_o <= 1'b0;
    // Only a settled value is written, which keeps wear on the store low while stepping.
    if (ud_step && up_on == dn_on && ud_q != nv_freq_o && hold_memory_selector_i == `DFC_HOLD_ON) begin
      nv_write_o <= 1'b1;
      nv_freq_o  <= ud_q;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Output ramp: one step per tick toward the target.
always @(posedge clk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    freq_q        <= `DFC_ZERO_FREQ;
    out_freq_o    <= `DFC_ZERO_FREQ;
    speed_agree_o <= 1'b0;
  end else begin
    if (tick && accel)
      freq_q <= freq_q + `DFC_FREQ_STEP;
    else if (tick && decel)
      freq_q <= freq_q - `DFC_FREQ_STEP;
    out_freq_o    <= freq_q;
    speed_agree_o <= run_cmd_i && !accel && !decel;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Fault reset on a rising edge, refused while running.
reg fr_q;
always @(posedge clk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    fr_q          <= 1'b0;
    fault_clear_o <= 1'b0;
  end else begin
    fr_q          <= fr_on;
    fault_clear_o <= fr_on && !fr_q && fault_i && !run_cmd_i;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Sample/hold: all analog channels captured once the input has stood for the full time.
reg [31:0] sh_cnt_q;
always @(posedge clk_i or negedge nrst_i) begin
  if (!nrst_i) begin
    sh_cnt_q      <= 32'h0000_0000;
    held_analog_o <= `DFC_ZERO_FREQ;
    held_aux_o    <= `DFC_ZERO_FREQ;
    held_card_o   <= `DFC_ZERO_FREQ;
  end else if (!sh_on || !has_sh) begin
    sh_cnt_q <= 32'h0000_0000;
  end else if (sh_cnt_q < SH_CYCLES) begin
    sh_cnt_q <= sh_cnt_q + 32'h0000_0001;
    if (sh_cnt_q == SH_CYCLES - 32'h0000_0001) begin
      held_analog_o <= analog_ref_i;
      held_aux_o    <= aux_analog_i;
      held_card_o   <= card_analog_i;
    end
  end
end

endmodule
`default_nettype wire

/* File: verif/dfc_freq_cmd_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module dfc_freq_cmd_asserts (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic [47:0] mfi_func_i,
  input wire logic        run_cmd_i,
  input wire logic        fault_i,
  input wire logic        fault_clear_o,
  input wire logic        param_wr_req_i,
  input wire logic        param_is_freq_i,
  input wire logic        param_wr_ok_o,
  input wire logic [15:0] analog_ref_i,
  input wire logic [15:0] card_analog_i,
  input wire logic [15:0] held_analog_o,
  input wire logic [15:0] held_card_o,
  input wire logic        speed_agree_o,
  input wire logic        nv_erase_o,
  input wire logic        multistep_en_o,
  input wire logic        missing_pair_setting_error_o,
  input wire logic        conflicting_function_error_o
);
  // Which functions are assigned anywhere; the error outputs are pure decodes of this.
  logic up, dn, rh, tr, sh;
  always_comb begin
    {up, dn, rh, tr, sh} = 5'h0;
    for (int n = 0; n < 6; n++) begin
      up |= mfi_func_i[8*n+:8] == 8'h10;
      dn |= mfi_func_i[8*n+:8] == 8'h11;
      rh |= mfi_func_i[8*n+:8] == 8'h0A;
      tr |= mfi_func_i[8*n+:8] inside {8'h1C, 8'h1D};
      sh |= mfi_func_i[8*n+:8] == 8'h1E;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_clear_needs_fault: assert property (fault_clear_o |-> $past(fault_i) && !$past(run_cmd_i))
    else $error("fault clear out of turn");
  a_clear_one_cycle: assert property (fault_clear_o |=> !fault_clear_o)
    else $error("fault clear too long");
  a_freq_write_ok: assert property (param_wr_req_i && param_is_freq_i |-> param_wr_ok_o)
    else $error("frequency write refused");
  a_pair_missing: assert property (missing_pair_setting_error_o == (up ^ dn))
    else $error("pair error wrong");
  a_excl_conflict: assert property (conflicting_function_error_o == (int'(rh) + int'(up | dn) + int'(tr) + int'(sh) > 1))
    else $error("conflict error wrong");
  a_steps_off: assert property (up && dn |-> !multistep_en_o)
    else $error("multi-step left on");
  a_agree_needs_run: assert property (!run_cmd_i && !$past(run_cmd_i) |-> !speed_agree_o)
    else $error("agree while stopped");
  a_erase_stopped: assert property (nv_erase_o |-> !$past(run_cmd_i))
    else $error("erase while running");
  a_sample_value: assert property ($changed(held_analog_o) |-> held_analog_o == $past(analog_ref_i))
    else $error("held value not sampled");
  a_sample_card: assert property ($changed(held_card_o) |-> held_card_o == $past(card_analog_i))
    else $error("card value not sampled");
endmodule
bind dfc_freq_cmd dfc_freq_cmd_asserts dfc_freq_cmd_asserts_i (.clk_i, .nrst_i, .mfi_func_i, .run_cmd_i, .fault_i,
  .fault_clear_o, .param_wr_req_i, .param_is_freq_i, .param_wr_ok_o, .analog_ref_i, .card_analog_i, .held_analog_o,
  .held_card_o, .speed_agree_o, .nv_erase_o, .multistep_en_o, .missing_pair_setting_error_o,
  .conflicting_function_error_o);
`default_nettype wire

/* File: verif/dfc_switch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dfc_switch_model (
  input  wire logic clk_i,
  output logic [5:0] pin_o,
  output logic       run_o
);
  initial begin
    pin_o = 6'h00;
    run_o = 1'b0;
  end
  task automatic set_pin(input int p, input logic v);
    @(negedge clk_i);
    pin_o[p] = v;
  endtask
  task automatic hold_pin(input int p, input int n);
    set_pin(p, 1'b1);
    repeat (n) @(negedge clk_i);
    pin_o[p] = 1'b0;
  endtask
  task automatic set_run(input logic v);
    @(negedge clk_i);
    run_o = v;
  endtask
  // The device ignores a reset while running, so run must drop before the pulse.
  task automatic resume(input int p);
    set_run(1'b0);
    hold_pin(p, 8);
    repeat (8) @(negedge clk_i);
    run_o = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: verif/dfc_freq_cmd_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dfc_freq_cmd_test;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [47:0] func = 48'h0619_1B14_1110;
  logic [1:0]  src = 2'h1;
  logic        asel = 1'b0, fault = 1'b0, req = 1'b0, isf = 1'b0, hold = 1'b0, nv_v = 1'b1;
  logic [15:0] aref = 16'h0000, aux = 16'h0000, card = 16'h0000, jog = 16'h0000, nv_f = 16'h0013;
  logic [15:0] rfreq = 16'h0000;
  wire  [5:0]  pins;
  wire  [15:0] freq, held_a, held_c, held_x, nv_fo;
  wire         run, clr, ers, agree, pid_en, ms_en, miss, conf, wr_ok, nv_wr;
  int          n_errors = 0, total_checks = 0, n_clr = 0, n_ers = 0, n_wr = 0;
  always #10 clk_i = ~clk_i;
  // Pulses are counted rather than caught, so a late or doubled one still shows.
  always @(posedge clk_i) begin
    if (clr === 1'b1) n_clr++;
    if (ers === 1'b1) n_ers++;
    if (nv_wr === 1'b1) n_wr++;
  end
  dfc_switch_model dfc_switch_model_i (.clk_i, .pin_o(pins), .run_o(run));
  // Sample time shortened to 20 cycles to keep the run brief.
  dfc_freq_cmd #(.SH_CYCLES(32'h0000_0014)) dfc_freq_cmd_i (.clk_i, .nrst_i, .mfi_pin_i(pins), .mfi_func_i(func),
    .run_cmd_i(run), .run_source_selector_i(src), .maximum_frequency_setting_i(16'h0064),
    .upper_limit_percent_i(8'h14), .lower_limit_percent_i(8'h0A), .hold_memory_selector_i(hold),
    .trim_level_setting_i(16'h0005), .ramp_time_i(16'h0001), .analog_ref_sel_i(asel), .analog_ref_i(aref),
    .aux_analog_i(aux), .card_analog_i(card), .jog_freq_i(jog), .ref_freq_i(rfreq), .nv_freq_i(nv_f),
    .nv_valid_i(nv_v), .nv_write_o(nv_wr), .nv_erase_o(ers), .nv_freq_o(nv_fo), .fault_i(fault),
    .fault_clear_o(clr), .param_wr_req_i(req), .param_is_freq_i(isf), .param_wr_ok_o(wr_ok), .out_freq_o(freq),
    .held_analog_o(held_a), .held_aux_o(held_x), .held_card_o(held_c), .speed_agree_o(agree),
    .pid_enable_o(pid_en),
    .multistep_en_o(ms_en), .missing_pair_setting_error_o(miss), .conflicting_function_error_o(conf));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic press(input int p, input int n);
    dfc_switch_model_i.hold_pin(p, n);
    cyc(8);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    cyc(3);
    nrst_i = 1'b1;
    cyc(2);
    chk(ms_en, 16'h0000);
    chk({miss, conf}, 16'h0000);
    press(0, 10);
    chk(16'(n_ers), 16'h0001);
    dfc_switch_model_i.set_run(1'b1);
    cyc(1000);
    chk(freq, 16'h000A);
    chk(agree, 16'h0001);
    hold = 1'b1;
    rfreq = 16'h000A;
    src = 2'h2;
    press(0, 1000);
    chk(freq, 16'h000A);
    src = 2'h1;
    press(0, 1200);
    chk(freq, 16'h0014);
    press(1, 1200);
    chk(freq, 16'h000A);
    asel = 1'b1;
    aref = 16'h000F;
    cyc(800);
    chk(freq, 16'h000F);
    asel = 1'b0;
    jog = 16'h0012;
    dfc_switch_model_i.set_pin(5, 1'b1);
    cyc(400);
    chk(freq, 16'h0012);
    dfc_switch_model_i.set_pin(5, 1'b0);
    cyc(400);
    chk(freq, 16'h000F);
    chk(nv_fo, 16'h000F);
    chk(16'(n_wr > 0), 16'h0001);
    fault = 1'b1;
    press(2, 8);
    chk(16'(n_clr), 16'h0000);
    nv_f = 16'h0011;
    dfc_switch_model_i.resume(2);
    chk(16'(n_clr), 16'h0001);
    cyc(400);
    chk(freq, 16'h0011);
    fault = 1'b0;
    dfc_switch_model_i.set_run(1'b0);
    press(2, 8);
    chk(16'(n_clr), 16'h0001);
    req = 1'b1;
    cyc(1);
    chk(wr_ok, 16'h0000);
    dfc_switch_model_i.set_pin(3, 1'b1);
    cyc(8);
    chk(wr_ok, 16'h0001);
    chk(pid_en, 16'h0001);
    dfc_switch_model_i.set_pin(4, 1'b1);
    cyc(8);
    chk(pid_en, 16'h0000);
    isf = 1'b1;
    func[15:8] = 8'h1E;
    cyc(1);
    chk({miss, conf}, 16'h0003);
    func[7:0] = 8'h0F;
    aref = 16'h0123;
    card = 16'h0456;
    aux = 16'h0789;
    cyc(1);
    chk({miss, conf}, 16'h0000);
    press(1, 10);
    chk(held_a, 16'h0000);
    press(1, 40);
    chk(held_a, 16'h0123);
    chk(held_c, 16'h0456);
    chk(held_x, 16'h0789);
    func[15:0] = 16'h1D1C;
    nv_v = 1'b0;
    asel = 1'b1;
    rfreq = 16'h0003;
    cyc(1);
    chk({ms_en, miss, conf}, 16'h0004);
    dfc_switch_model_i.set_run(1'b1);
    dfc_switch_model_i.set_pin(0, 1'b1);
    cyc(1000);
    chk(freq, 16'h0008);
    dfc_switch_model_i.set_pin(1, 1'b1);
    cyc(400);
    chk(freq, 16'h0003);
    dfc_switch_model_i.set_pin(0, 1'b0);
    cyc(400);
    chk(freq, 16'h0000);
    asel = 1'b0;
    cyc(400);
    chk(freq, 16'h0003);
    test_done;
  end
  initial begin
    cyc(20000);
    n_errors++;
    test_done;
  end
endmodule
`default_nettype wire
